/* File: design/asss_sequencer.sv */
// ahb-lite slave with write stall on phase-one edge and successive-approximation stepping
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module asss_sequencer (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        phase_one_clock,
    input  wire logic [3:0]  comparator_bus,
    output logic      [7:0]  dac_value,
    output logic             sync_stall_enable
);

    localparam int NSYNC = asss_pkg::ASSS_COLUMNS + 1;

    // index decode, used for both the address phase and the data phase
    function automatic logic asss_is_sc(input logic [7:0] idx);
        asss_is_sc = (idx == asss_pkg::ASSS_IDX_DAC_VALUE) || (idx == asss_pkg::ASSS_IDX_DAC_OR);
    endfunction : asss_is_sc

    function automatic logic asss_is_mapped(input logic [7:0] idx);
        asss_is_mapped = asss_is_sc(idx) || (idx == asss_pkg::ASSS_IDX_SYNC_CTRL);
    endfunction : asss_is_mapped

    // three-stage synchronisers: bit 0 phase-one clock, bits 4:1 comparator columns
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] sync3_q;
    logic [NSYNC-1:0] filt_q;
    logic [NSYNC-1:0] filt_d;
    logic [NSYNC-1:0] raw_in;

    assign raw_in = {comparator_bus, phase_one_clock};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // a change is taken only once stages two and three agree
            assign filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync2_q[gi] : filt_q[gi];
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                    filt_q[gi]  <= 1'b0;
                end else if (clk_en) begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    filt_q[gi]  <= filt_d[gi];
                end
            end
        end
    endgenerate

    logic phase_one_clock_rise;
    assign phase_one_clock_rise = filt_d[0] & ~filt_q[0];

    // control state
    logic       en_q;
    logic [1:0] col_q;
    logic       pol_q;
    logic [2:0] cnt_q;
    logic [2:0] pos_q;
    logic [7:0] dac_q;

    // bus address and data phase
    asss_pkg::asss_phase_t ph_q;
    asss_pkg::asss_phase_t ph_d;
    logic [7:0]            ph_idx_q;
    logic                  ph_map_q;
    logic [7:0]            a_idx;
    logic                  a_ok;
    logic                  accept;

    assign a_idx  = haddr[asss_pkg::ASSS_IDX_MSB:asss_pkg::ASSS_IDX_LSB];
    assign a_ok   = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) && asss_is_mapped(a_idx);
    assign accept = hsel & hready & htrans[1];
    assign ph_d   = !accept ? asss_pkg::ASSS_PH_IDLE
                  : hwrite  ? asss_pkg::ASSS_PH_WRITE : asss_pkg::ASSS_PH_READ;

    // stall an enabled switched-cap write data phase until phase one rises; a clock slower than the
    // column clock by a power of two can alias the edge away, the hazard
    logic stall_w;
    assign stall_w   = (ph_q == asss_pkg::ASSS_PH_WRITE) && ph_map_q && asss_is_sc(ph_idx_q)
                     && en_q && !phase_one_clock_rise;
    assign hreadyout = !stall_w;
    assign hresp     = 1'b0;
    // no error response: unmapped reads give zero, unmapped writes are dropped

    logic commit;
    logic wr_ctrl;
    logic wr_dac;
    logic wr_or;
    assign commit  = clk_en && (ph_q == asss_pkg::ASSS_PH_WRITE) && ph_map_q && !stall_w;
    assign wr_ctrl = commit && (ph_idx_q == asss_pkg::ASSS_IDX_SYNC_CTRL);
    assign wr_dac  = commit && (ph_idx_q == asss_pkg::ASSS_IDX_DAC_VALUE);
    assign wr_or   = commit && (ph_idx_q == asss_pkg::ASSS_IDX_DAC_OR);

    // successive-approximation step
    logic       cmp_col;
    logic       keep_w;
    logic       step_w;
    logic [7:0] tmask_w;
    logic [7:0] nmask_w;
    logic [7:0] cleared_w;
    logic [7:0] or_w;
    logic [7:0] dac_d;
    logic [2:0] new_cnt;

    assign cmp_col   = filt_q[1 + col_q];
    assign keep_w    = cmp_col ^ pol_q;
    assign step_w    = wr_or && (cnt_q != asss_pkg::ASSS_CNT_RESET);
    // the last step sets no new guess, so bit 0 is final once tested
    assign tmask_w   = 8'h01 << pos_q;
    assign nmask_w   = (pos_q != 3'h0) ? (8'h01 << (pos_q - 3'h1)) : 8'h00;
    assign cleared_w = (step_w && !keep_w) ? (dac_q & ~tmask_w) : dac_q;
    assign or_w      = cleared_w | hwdata[7:0] | (step_w ? nmask_w : 8'h00);
    assign dac_d     = wr_dac ? hwdata[7:0] : (wr_or ? or_w : dac_q);
    assign new_cnt   = hwdata[asss_pkg::ASSS_CNT_MSB:asss_pkg::ASSS_CNT_LSB];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ph_q     <= asss_pkg::ASSS_PH_IDLE;
            ph_idx_q <= 8'h00;
            ph_map_q <= 1'b0;
        end else if (clk_en && hreadyout) begin
            ph_q     <= ph_d;
            ph_idx_q <= a_idx;
            ph_map_q <= a_ok;
        end
    end

    // a control write restarts the conversion at the sign bit
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            en_q  <= 1'b0;
            col_q <= 2'h0;
            pol_q <= 1'b0;
            cnt_q <= asss_pkg::ASSS_CNT_RESET;
            pos_q <= 3'h0;
        end else if (wr_ctrl) begin
            en_q  <= hwdata[asss_pkg::ASSS_EN_BIT];
            col_q <= hwdata[asss_pkg::ASSS_COL_MSB:asss_pkg::ASSS_COL_LSB];
            pol_q <= hwdata[asss_pkg::ASSS_POL_BIT];
            cnt_q <= new_cnt;
            // first tested bit is the sign bit, one below the count
            pos_q <= (new_cnt != 3'h0) ? (new_cnt - 3'h1) : 3'h0;
        end else if (step_w) begin
            cnt_q <= cnt_q - 3'h1;
            pos_q <= (pos_q != 3'h0) ? (pos_q - 3'h1) : 3'h0;
        end
    end

    // plain writes and or steps share one flop bank; clk_en gates both
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dac_q <= asss_pkg::ASSS_DAC_RESET;
        end else if (clk_en) begin
            dac_q <= dac_d;
        end
    end

    // read data muxed from flops; reserved bit 7 and upper lanes read zero
    logic [7:0] ctrl_rd;
    logic [7:0] rd_byte;
    assign ctrl_rd = {1'b0, cnt_q, pol_q, col_q, en_q};
    assign rd_byte = !ph_map_q ? 8'h00
                   : (ph_idx_q == asss_pkg::ASSS_IDX_SYNC_CTRL) ? ctrl_rd : dac_q;
    assign hrdata  = (ph_q == asss_pkg::ASSS_PH_READ) ? {24'h000000, rd_byte} : 32'h00000000;

    assign dac_value         = dac_q;
    assign sync_stall_enable = en_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_stall_holds_write: assert property (
        (ph_q == asss_pkg::ASSS_PH_WRITE) && ph_map_q && asss_is_sc(ph_idx_q) && en_q
        && !phase_one_clock_rise |-> !hreadyout)
        else $error("switched-cap write not stalled before phase-one edge");

    a_stall_ends_edge: assert property (
        (ph_q == asss_pkg::ASSS_PH_WRITE) && phase_one_clock_rise |-> hreadyout)
        else $error("stall did not end on phase-one edge");

    a_enable_persists: assert property (
        clk_en && en_q && !wr_ctrl |=> en_q)
        else $error("sync stall enable dropped without software clear");

    a_enable_bit_zero: assert property (
        wr_ctrl |=> en_q == $past(hwdata[0]))
        else $error("enable bit not taken from bit 0");

    a_count_loaded: assert property (
        wr_ctrl |=> cnt_q == $past(new_cnt) && ctrl_rd[6:4] == $past(new_cnt))
        else $error("bit count not loaded from bits 6:4");

    a_guess_cleared: assert property (
        step_w && (cmp_col == pol_q) && ((hwdata[7:0] & tmask_w) == 8'h00)
        |=> (dac_q & $past(tmask_w)) == 8'h00)
        else $error("too-high guess was not cleared");

    a_guess_kept: assert property (
        step_w && (cmp_col != pol_q) |=> (dac_q & $past(tmask_w)) != 8'h00)
        else $error("valid guess was cleared");

    a_next_guess_set: assert property (
        step_w && (pos_q != 3'h0) |=> (dac_q & $past(nmask_w)) != 8'h00)
        else $error("next lower guess bit not set");

    a_count_steps: assert property (
        step_w |=> cnt_q == $past(cnt_q) - 3'h1)
        else $error("bit count did not decrement on step");

    a_count_zero_idle: assert property (
        wr_or && (cnt_q == 3'h0) && (hwdata[7:0] == 8'h00) |=> $stable(dac_q) && cnt_q == 3'h0)
        else $error("dac modified after count reached zero");

    a_dac_readback: assert property (
        (ph_q == asss_pkg::ASSS_PH_READ) && ph_map_q && (ph_idx_q != asss_pkg::ASSS_IDX_SYNC_CTRL)
        |-> hrdata[7:0] == dac_q)
        else $error("dac read does not return dac value");

    a_reset_clears: assert property (
        disable iff (1'b0) reset |=> ctrl_rd == asss_pkg::ASSS_CTRL_RESET && !sync_stall_enable)
        else $error("control not zero after reset");

    // bus side: only switched-cap writes may wait, and only for phase one
    a_stall_no_commit: assert property (
        (ph_q == asss_pkg::ASSS_PH_WRITE) && ph_map_q && asss_is_sc(ph_idx_q) && en_q
        && !phase_one_clock_rise |=> $stable(dac_q))
        else $error("dac changed during a stalled write");

    a_ctrl_never_stalls: assert property (
        (ph_q == asss_pkg::ASSS_PH_WRITE) && (ph_idx_q == asss_pkg::ASSS_IDX_SYNC_CTRL)
        |-> hreadyout)
        else $error("control register write was stalled");

    a_no_stall_disabled: assert property (
        !en_q |-> hreadyout)
        else $error("bus stalled with sync stall disabled");

    a_read_no_wait: assert property (
        (ph_q != asss_pkg::ASSS_PH_WRITE) |-> hreadyout)
        else $error("read or idle phase inserted a wait state");

    a_rdata_no_read: assert property (
        (ph_q != asss_pkg::ASSS_PH_READ) |-> hrdata == 32'h00000000)
        else $error("read data not zero outside a read phase");

    // synchroniser: one rise pulse per phase-one edge
    a_sync_filter_hold: assert property (
        sync2_q[0] != sync3_q[0] |=> $stable(filt_q[0]))
        else $error("phase-one filter moved while stages disagree");

    a_rise_one_cycle: assert property (
        clk_en && phase_one_clock_rise |=> !phase_one_clock_rise)
        else $error("phase-one rise held for more than one cycle");

    // sequencer: loads, single steps and holds between steps
    a_sense_loaded: assert property (
        wr_ctrl |=> pol_q == $past(hwdata[asss_pkg::ASSS_POL_BIT])
        && col_q == $past(hwdata[asss_pkg::ASSS_COL_MSB:asss_pkg::ASSS_COL_LSB]))
        else $error("polarity or column not loaded");

    a_position_tracks: assert property (
        cnt_q != 3'h0 |-> pos_q == cnt_q - 3'h1)
        else $error("tested bit does not follow remaining count");

    a_step_touches_two: assert property (
        step_w && (hwdata[7:0] == 8'h00)
        |=> ((dac_q ^ $past(dac_q)) & ~($past(tmask_w) | $past(nmask_w))) == 8'h00)
        else $error("step changed a bit other than tested or next");

    a_last_step_final: assert property (
        step_w && (pos_q == 3'h0) && (hwdata[7:0] == 8'h00)
        |=> (dac_q | 8'h01) == ($past(dac_q) | 8'h01))
        else $error("last step touched a bit above bit 0");

    a_dac_plain_write: assert property (
        wr_dac |=> dac_q == $past(hwdata[7:0]))
        else $error("dac value write not stored");

    a_dac_holds_idle: assert property (
        !wr_dac && !wr_or |=> $stable(dac_q))
        else $error("dac changed without a write");

    a_count_holds_idle: assert property (
        !wr_ctrl && !step_w |=> $stable(cnt_q))
        else $error("bit count changed without a step");

    a_freeze_on_enable: assert property (
        !clk_en |=> $stable(dac_q) && $stable(cnt_q) && $stable(en_q))
        else $error("state changed while clock enable low");

endmodule : asss_sequencer

/* File: design/asss_pkg.sv */
// constants for the analog sync stall and successive-approximation sequencer
package asss_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] ASSS_IDX_SYNC_CTRL = 8'h65;
    localparam logic [7:0] ASSS_IDX_DAC_VALUE = 8'h66;
    localparam logic [7:0] ASSS_IDX_DAC_OR    = 8'h67;
    localparam int         ASSS_IDX_LSB       = 2;
    localparam int         ASSS_IDX_MSB       = 9;
    // control field positions
    localparam int ASSS_EN_BIT  = 0;
    localparam int ASSS_COL_LSB = 1;
    localparam int ASSS_COL_MSB = 2;
    localparam int ASSS_POL_BIT = 3;
    localparam int ASSS_CNT_LSB = 4;
    localparam int ASSS_CNT_MSB = 6;
    // reset values and column count
    localparam logic [7:0] ASSS_CTRL_RESET = 8'h00;
    localparam logic [7:0] ASSS_DAC_RESET  = 8'h00;
    localparam logic [2:0] ASSS_CNT_RESET  = 3'h0;
    localparam int         ASSS_COLUMNS    = 4;
    // data phase of the bus slave, gray coded
    typedef enum logic [1:0] {
        ASSS_PH_IDLE  = 2'b00,
        ASSS_PH_READ  = 2'b01,
        ASSS_PH_WRITE = 2'b11
    } asss_phase_t;
endpackage : asss_pkg

/* File: sim/asss_analog_model.sv */
// behavioural analog column: phase-one clock and comparator bus
`timescale 1ns/100ps
module asss_analog_model (
    input  wire logic [7:0] dac_value,
    input  wire logic [7:0] analog_level,
    input  wire logic [1:0] column,
    output logic            phase_one_clock,
    output logic      [3:0] comparator_bus
);
    logic above;
    // slower than the cpu clock and not a power-of-two multiple above it
    initial begin
        phase_one_clock = 1'b0;
        forever #150 phase_one_clock = ~phase_one_clock;
    end
    // other columns disagree so a wrong column pick shows
    assign above = dac_value > analog_level;
    always_comb begin
        comparator_bus         = {4{above}};
        comparator_bus[column] = ~above;
    end
endmodule : asss_analog_model

/* File: sim/analog_sync_sar_sequencer_tb.sv */
// self-checking bench: register access, write stall and sar stepping
`timescale 1ns/100ps
module analog_sync_sar_sequencer_tb;
    logic        clk_sys, reset, clk_en, hwrite, p1, hreadyout, hresp, sync_stall_enable;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, mcol;
    logic [7:0]  dac_value, level;
    logic [3:0]  comparator_bus;
    int          n_mismatch, samples_checked, waited;

    asss_sequencer u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .phase_one_clock(p1), .comparator_bus(comparator_bus), .dac_value(dac_value),
        .sync_stall_enable(sync_stall_enable));
    asss_analog_model u_model (.dac_value(dac_value), .analog_level(level), .column(mcol),
        .phase_one_clock(p1), .comparator_bus(comparator_bus));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ready and read data are taken before the edge, equal to their value at it
    task automatic wait_ready();
        logic r;
        r      = 1'b0;
        waited = 0;
        while (!r) begin
            @(negedge clk_sys);
            r  = (hreadyout === 1'b1);
            rd = hrdata;
            @(posedge clk_sys);
            waited++;
            if (waited > 2000) begin
                n_mismatch++;
                summarize();
            end
        end
    endtask : wait_ready

    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
    endtask : xfer

    function automatic logic [7:0] sar(input logic [7:0] v, input logic p);
        logic [7:0] d;
        d = 8'h00;
        for (int b = 5; b >= 0; b--) begin
            d[b] = 1'b1;
            if (((d <= v) ^ p) == 1'b0)
                d[b] = 1'b0;
        end
        return d;
    endfunction : sar

    initial begin
        reset  = 1'b1;
        clk_en = 1'b1;
        haddr  = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        mcol   = 2'h0;
        level  = 8'h2B;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        xfer(asss_pkg::ASSS_IDX_SYNC_CTRL, 1'b0, 8'h00);
        check(rd, 32'h0);
        xfer(asss_pkg::ASSS_IDX_DAC_VALUE, 1'b0, 8'h00);
        check(rd, 32'h0);
        xfer(asss_pkg::ASSS_IDX_SYNC_CTRL, 1'b1, 8'hFE);
        xfer(asss_pkg::ASSS_IDX_SYNC_CTRL, 1'b0, 8'h00);
        check(rd, 32'h7E);
        xfer(8'h70, 1'b1, 8'h55);
        xfer(8'h70, 1'b0, 8'h00);
        check(rd, 32'h0);
        xfer(asss_pkg::ASSS_IDX_SYNC_CTRL, 1'b1, 8'h01);
        repeat (2) begin
            xfer(asss_pkg::ASSS_IDX_DAC_VALUE, 1'b1, 8'h11);
            check(32'(waited > 1), 32'h1);
            // enable is settled here, well clear of the edge that wrote it
            check({31'h0, sync_stall_enable}, 32'h1);
        end
        xfer(asss_pkg::ASSS_IDX_SYNC_CTRL, 1'b1, 8'h00);
        xfer(asss_pkg::ASSS_IDX_DAC_VALUE, 1'b1, 8'h22);
        check(32'(waited), 32'h1);
        for (int c = 0; c < 4; c++) begin
            for (int p = 0; p < 2; p++) begin
                mcol <= 2'(c);
                xfer(asss_pkg::ASSS_IDX_SYNC_CTRL, 1'b1, {1'b0, 3'h6, 1'(p), 2'(c), 1'(p)});
                xfer(asss_pkg::ASSS_IDX_DAC_VALUE, 1'b1, 8'h20);
                repeat (6) begin
                    repeat (5) @(posedge clk_sys);
                    xfer(asss_pkg::ASSS_IDX_DAC_OR, 1'b1, 8'h00);
                end
                xfer(asss_pkg::ASSS_IDX_DAC_VALUE, 1'b0, 8'h00);
                check(rd, {24'h0, sar(level, 1'(p))});
            end
        end
        xfer(asss_pkg::ASSS_IDX_SYNC_CTRL, 1'b0, 8'h00);
        check(rd, 32'h0F);
        repeat (5) @(posedge clk_sys);
        xfer(asss_pkg::ASSS_IDX_DAC_OR, 1'b1, 8'h80);
        xfer(asss_pkg::ASSS_IDX_DAC_OR, 1'b0, 8'h00);
        check(rd, {24'h0, sar(level, 1'b1) | 8'h80});
        check({24'h0, dac_value}, {24'h0, sar(level, 1'b1) | 8'h80});
        check({31'h0, hresp}, 32'h0);
        summarize();
    end
endmodule : analog_sync_sar_sequencer_tb
